// file: verilog/mdl_top.sv
// Functional notes
// - Latch source value at mark input edge.
// - Range check first; outside values are dropped.
// - Exactly three storage modes by configuration.
// - Continuous mode overwrites the one location.
// - Fixed-count mode stores until count reached.
// - Ring mode stores into successive slots.
// - Slot stride is 1, 2 or 4 words.
// - Capture on configured rising or falling edge.
// - Fixed-count compares counter before deciding store.
// - Write value first, then increment counter.
// - Detection count accepts 1 to 8192.
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "mdl_defines.svh"

module mdl_top import mdl_pkg::*; (
	input  wire logic        CLK_SYS,         // System clock, 50 MHz.
	input  wire logic        RST,             // Synchronous reset, active high.
	input  wire logic        MARK_IN,         // Mark sensor pin.
	input  wire logic [63:0] DATA_IN,         // Source value to latch.
	input  wire logic [15:0] AVS_ADDRESS,     // Word address.
	input  wire logic        AVS_READ,        // Read request.
	input  wire logic        AVS_WRITE,       // Write request.
	input  wire logic [31:0] AVS_WRITEDATA,   // Write data.
	input  wire logic [3:0]  AVS_BYTEENABLE,  // Byte lanes.
	output logic      [31:0] AVS_READDATA,    // Read data.
	output logic             AVS_WAITREQUEST  // Low for the answer cycle.
);

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	mdl_store_if store ();

	logic        en_ff, fall_ff, rng_ff;
	mdl_mode_t   mode_ff;
	mdl_dtype_t  dtype_ff;
	logic [13:0] num_ff;
	logic [31:0] cnt_ff;
	logic [12:0] ring_ff;
	logic [63:0] upper_ff, lower_ff, cap_ff, last_ff;
	mdl_state_t  state_ff;
	mdl_mode_t   cmode_ff;
	logic [2:0]  stride_ff;
	logic [1:0]  word_ff;
	logic [14:0] base_ff;
	logic        ack_ff;
	logic [31:0] rdata_ff;
	logic        mark_lvl, mark_edge;
	logic        bus_req, bus_wr, cnt_clr, in_range, full, accept;
	logic [12:0] nxt_slot;
	logic [2:0]  nxt_stride;

	// ****************************************************************
	// Helpers.
	// ****************************************************************

	// Order-preserving unsigned key, so one comparator serves all types.
	function automatic logic [63:0] ord_key(input logic [63:0] v, input mdl_dtype_t t);
		case (t)
			MDL_I16: ord_key = {~v[15], {48{v[15]}}, v[14:0]};
			MDL_I32: ord_key = {~v[31], {32{v[31]}}, v[30:0]};
			default: ord_key = v[63] ? ~v : {1'b1, v[62:0]};
		endcase
	endfunction

	// Byte-lane merge of a bus write into a 32-bit word.
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		be_merge = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				be_merge[8*i +: 8] = wd[8*i +: 8];
			end
		end
	endfunction

	// ****************************************************************
	// Mark input and storage area.
	// ****************************************************************
	mdl_mark_sync u_sync (
		.clk        (CLK_SYS),
		.rst        (RST),
		.pin        (MARK_IN),
		.fall_sel   (fall_ff),
		.level      (mark_lvl),
		.edge_pulse (mark_edge)
	);

	mdl_store_mem u_mem (
		.clk  (CLK_SYS),
		.port (store.mem)
	);

	// ****************************************************************
	// Avalon-MM slave.
	// ****************************************************************

	// A request is answered one cycle after it appears, never twice; a write lands
	// only at the answer edge, where the master sees waitrequest low.
	assign bus_req = (AVS_READ || AVS_WRITE) && !ack_ff;
	assign bus_wr  = ack_ff && AVS_WRITE;
	assign cnt_clr = bus_wr && AVS_ADDRESS == `MDL_REG_COUNTER && AVS_WRITEDATA == 32'h0;
	assign store.rd_addr = AVS_ADDRESS[14:0];

	// Handshake and read data; unmapped addresses read zero.
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h0;
		end else begin
			ack_ff <= bus_req;
			if (bus_req && AVS_READ) begin
				if (AVS_ADDRESS[`MDL_MEM_SEL_BIT]) begin
					rdata_ff <= {16'h0, store.rd_data};
				end else if (AVS_ADDRESS == `MDL_REG_CTRL) begin
					rdata_ff <= {25'h0, dtype_ff, rng_ff, fall_ff, mode_ff, en_ff};
				end else if (AVS_ADDRESS == `MDL_REG_NUM_DET) begin
					rdata_ff <= {18'h0, num_ff};
				end else if (AVS_ADDRESS == `MDL_REG_COUNTER) begin
					rdata_ff <= cnt_ff;
				end else if (AVS_ADDRESS == `MDL_REG_UPPER_LO) begin
					rdata_ff <= upper_ff[31:0];
				end else if (AVS_ADDRESS == `MDL_REG_UPPER_HI) begin
					rdata_ff <= upper_ff[63:32];
				end else if (AVS_ADDRESS == `MDL_REG_LOWER_LO) begin
					rdata_ff <= lower_ff[31:0];
				end else if (AVS_ADDRESS == `MDL_REG_LOWER_HI) begin
					rdata_ff <= lower_ff[63:32];
				end else if (AVS_ADDRESS == `MDL_REG_STATUS) begin
					rdata_ff <= {29'h0, full, state_ff != ST_IDLE, mark_lvl};
				end else if (AVS_ADDRESS == `MDL_REG_LAST_LO) begin
					rdata_ff <= last_ff[31:0];
				end else if (AVS_ADDRESS == `MDL_REG_LAST_HI) begin
					rdata_ff <= last_ff[63:32];
				end else begin
					rdata_ff <= 32'h0;
				end
			end
		end
	end

	assign AVS_READDATA    = rdata_ff;
	assign AVS_WAITREQUEST = !ack_ff;

	// Configuration writes; illegal mode, type or count codes are ignored.
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			en_ff    <= 1'b0;
			fall_ff  <= 1'b0;
			rng_ff   <= 1'b0;
			mode_ff  <= MDL_CONT;
			dtype_ff <= MDL_I16;
			num_ff   <= `MDL_NUM_RST;
			upper_ff <= 64'h0;
			lower_ff <= 64'h0;
		end else if (bus_wr) begin
			if (AVS_ADDRESS == `MDL_REG_CTRL) begin
				if (AVS_BYTEENABLE[0]) begin
					en_ff   <= AVS_WRITEDATA[`MDL_CTRL_EN_BIT];
					fall_ff <= AVS_WRITEDATA[`MDL_CTRL_FALL_BIT];
					rng_ff  <= AVS_WRITEDATA[`MDL_CTRL_RNG_BIT];
					if (AVS_WRITEDATA[`MDL_CTRL_MODE_LSB +: 2] != 2'h3) begin
						mode_ff <= mdl_mode_t'(AVS_WRITEDATA[`MDL_CTRL_MODE_LSB +: 2]);
					end
					if (AVS_WRITEDATA[`MDL_CTRL_TYPE_LSB +: 2] != 2'h3) begin
						dtype_ff <= mdl_dtype_t'(AVS_WRITEDATA[`MDL_CTRL_TYPE_LSB +: 2]);
					end
				end
			end else if (AVS_ADDRESS == `MDL_REG_NUM_DET) begin
				if (AVS_WRITEDATA[13:0] >= `MDL_NUM_MIN && AVS_WRITEDATA[13:0] <= `MDL_NUM_MAX
					&& AVS_WRITEDATA[31:14] == 18'h0) begin
					num_ff <= AVS_WRITEDATA[13:0];
				end
			end else if (AVS_ADDRESS == `MDL_REG_UPPER_LO) begin
				upper_ff[31:0] <= be_merge(upper_ff[31:0], AVS_WRITEDATA, AVS_BYTEENABLE);
			end else if (AVS_ADDRESS == `MDL_REG_UPPER_HI) begin
				upper_ff[63:32] <= be_merge(upper_ff[63:32], AVS_WRITEDATA, AVS_BYTEENABLE);
			end else if (AVS_ADDRESS == `MDL_REG_LOWER_LO) begin
				lower_ff[31:0] <= be_merge(lower_ff[31:0], AVS_WRITEDATA, AVS_BYTEENABLE);
			end else if (AVS_ADDRESS == `MDL_REG_LOWER_HI) begin
				lower_ff[63:32] <= be_merge(lower_ff[63:32], AVS_WRITEDATA, AVS_BYTEENABLE);
			end
		end
	end

	// ****************************************************************
	// Capture decision.
	// ****************************************************************

	// The range test looks at the live source value in the edge cycle.
	assign in_range = !rng_ff || (ord_key(DATA_IN, dtype_ff) <= ord_key(upper_ff, dtype_ff)
		&& ord_key(DATA_IN, dtype_ff) >= ord_key(lower_ff, dtype_ff));
	assign full   = mode_ff == MDL_FIXED && cnt_ff >= {18'h0, num_ff};
	assign accept = state_ff == ST_IDLE && en_ff && mark_edge && in_range && !full;

	// Slot by mode; counter values reaching here are below the count.
	always_comb begin
		case (mode_ff)
			MDL_FIXED: nxt_slot = cnt_ff[12:0];
			MDL_RING:  nxt_slot = ring_ff;
			default:   nxt_slot = 13'h0;
		endcase
		case (dtype_ff)
			MDL_I32: nxt_stride = `MDL_STRIDE_I32;
			MDL_F64: nxt_stride = `MDL_STRIDE_F64;
			default: nxt_stride = `MDL_STRIDE_I16;
		endcase
	end

	// ****************************************************************
	// Capture sequencer: write the words, then count.
	// ****************************************************************

	// The value is held at accept so slow writes see the edge-time data.
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			state_ff  <= ST_IDLE;
			cap_ff    <= 64'h0;
			cmode_ff  <= MDL_CONT;
			stride_ff <= `MDL_STRIDE_I16;
			word_ff   <= 2'h0;
			base_ff   <= 15'h0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (accept) begin
						cap_ff    <= DATA_IN;
						cmode_ff  <= mode_ff;
						stride_ff <= nxt_stride;
						word_ff   <= 2'h0;
						base_ff   <= {2'h0, nxt_slot} << nxt_stride[2:1];
						state_ff  <= ST_WRITE;
					end
				end
				ST_WRITE: begin
					word_ff <= word_ff + 2'h1;
					if ({1'b0, word_ff} == stride_ff - 3'h1) begin
						state_ff <= ST_COUNT;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	assign store.wr_en   = state_ff == ST_WRITE;
	assign store.wr_addr = base_ff + {13'h0, word_ff};
	assign store.wr_data = cap_ff[16*word_ff +: 16];

	// Counter and ring position; a count in the clear cycle is kept.
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			cnt_ff  <= 32'h0;
			ring_ff <= 13'h0;
			last_ff <= 64'h0;
		end else if (state_ff == ST_COUNT) begin
			cnt_ff  <= (cnt_clr ? 32'h0 : cnt_ff) + 32'h1;
			last_ff <= cap_ff;
			if (cmode_ff == MDL_RING) begin
				if (cnt_clr || {1'b0, ring_ff} >= num_ff - 14'h1) begin
					ring_ff <= 13'h0;
				end else begin
					ring_ff <= ring_ff + 13'h1;
				end
			end
		end else if (cnt_clr) begin
			cnt_ff  <= 32'h0;
			ring_ff <= 13'h0;
		end
	end

	// ****************************************************************
	// Assertions and covers.
	// ****************************************************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	AST_CAPTURE_VALUE: assert property (accept |=> cap_ff == $past(DATA_IN) && store.wr_en)
		else $error("capture does not hold edge value");
	AST_RANGE_DROP: assert property (state_ff == ST_IDLE && mark_edge && !in_range && !cnt_clr |=>
		state_ff == ST_IDLE && $stable(cnt_ff))
		else $error("out of range value was counted");
	AST_MODE_LEGAL: assert property (mode_ff != mdl_mode_t'(2'h3))
		else $error("illegal storage mode");
	AST_CONT_SLOT: assert property (store.wr_en && cmode_ff == MDL_CONT |->
		store.wr_addr < 15'h4)
		else $error("continuous store off slot zero");
	AST_FIXED_LIMIT: assert property (state_ff == ST_COUNT && cmode_ff == MDL_FIXED |->
		cnt_ff < {18'h0, num_ff})
		else $error("fixed count exceeded");
	AST_RING_SLOT: assert property (store.wr_en && cmode_ff == MDL_RING |->
		(store.wr_addr >> stride_ff[2:1]) < {1'b0, num_ff})
		else $error("ring slot beyond count");
	AST_STRIDE: assert property (state_ff == ST_COUNT |->
		$past(store.wr_en) && {1'b0, $past(word_ff)} == stride_ff - 3'h1)
		else $error("wrong number of words stored");
	AST_COUNT_AFTER_WRITE: assert property (cnt_ff != $past(cnt_ff) && cnt_ff != 32'h0 |->
		$past(state_ff, 2) == ST_WRITE)
		else $error("counter moved without a store");
	AST_NUM_RANGE: assert property (num_ff >= `MDL_NUM_MIN && num_ff <= `MDL_NUM_MAX)
		else $error("detection count out of range");
	AST_CLEAR: assert property (cnt_clr && state_ff != ST_COUNT |=> cnt_ff == 32'h0)
		else $error("counter not cleared");
	AST_RING_WRAP: assert property (state_ff == ST_COUNT && cmode_ff == MDL_RING && !cnt_clr &&
		{1'b0, ring_ff} >= num_ff - 14'h1 |=> ring_ff == 13'h0)
		else $error("ring did not wrap");
	AST_FULL_IGNORE: assert property (state_ff == ST_IDLE && mark_edge && full |=>
		state_ff == ST_IDLE [*2])
		else $error("edge taken while full");

	COV_RING_WRAP: cover property (state_ff == ST_COUNT && cmode_ff == MDL_RING &&
		{1'b0, ring_ff} >= num_ff - 14'h1);
	COV_FULL_EDGE: cover property (mark_edge && full && en_ff);
	COV_RANGE_DROP: cover property (mark_edge && en_ff && !in_range);
	COV_F64_STORE: cover property (state_ff == ST_COUNT && stride_ff == `MDL_STRIDE_F64);

endmodule // mdl_top

`default_nettype wire

// file: common/mdl_defines.svh
`ifndef MDL_DEFINES_SVH
`define MDL_DEFINES_SVH

// ****************************************************************
// Register word indices on the Avalon-MM slave.
// ****************************************************************
`define MDL_REG_CTRL     16'h0000
`define MDL_REG_NUM_DET  16'h0001
`define MDL_REG_COUNTER  16'h0002
`define MDL_REG_UPPER_LO 16'h0003
`define MDL_REG_UPPER_HI 16'h0004
`define MDL_REG_LOWER_LO 16'h0005
`define MDL_REG_LOWER_HI 16'h0006
`define MDL_REG_STATUS   16'h0007
`define MDL_REG_LAST_LO  16'h0008
`define MDL_REG_LAST_HI  16'h0009
// Address bit that selects the storage window (read only).
`define MDL_MEM_SEL_BIT  15

// ****************************************************************
// Control register fields.
// ****************************************************************
`define MDL_CTRL_EN_BIT   0
`define MDL_CTRL_MODE_LSB 1
`define MDL_CTRL_FALL_BIT 3
`define MDL_CTRL_RNG_BIT  4
`define MDL_CTRL_TYPE_LSB 5

// ****************************************************************
// Sizes, limits and reset values.
// ****************************************************************
`define MDL_NUM_MIN    14'h0001
`define MDL_NUM_MAX    14'h2000
`define MDL_NUM_RST    14'h0001
`define MDL_MEM_AW     15
`define MDL_MEM_DEPTH  32768
`define MDL_STRIDE_I16 3'h1
`define MDL_STRIDE_I32 3'h2
`define MDL_STRIDE_F64 3'h4

`endif

// file: common/mdl_pkg.sv
package mdl_pkg;

	// Storage mode; the register encoding follows declaration order.
	typedef enum logic [1:0] {MDL_CONT, MDL_FIXED, MDL_RING} mdl_mode_t;

	// Data type of the latched value.
	typedef enum logic [1:0] {MDL_I16, MDL_I32, MDL_F64} mdl_dtype_t;

	// Capture sequencer states.
	typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_COUNT} mdl_state_t;

endpackage

// file: common/mdl_store_if.sv
`timescale 1ns/100ps
`default_nettype none

// Storage area port: one write port for captures, one read port for the bus.
interface mdl_store_if;
	logic        wr_en;
	logic [14:0] wr_addr;
	logic [15:0] wr_data;
	logic [14:0] rd_addr;
	logic [15:0] rd_data;

	modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
	modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

`default_nettype wire

// file: verilog/mdl_mark_sync.sv
`timescale 1ns/100ps
`default_nettype none

module mdl_mark_sync (
	input  wire logic clk,        // System clock.
	input  wire logic rst,        // Synchronous reset, active high.
	input  wire logic pin,        // Asynchronous mark input.
	input  wire logic fall_sel,   // High selects the falling edge.
	output logic      level,      // Filtered mark level.
	output logic      edge_pulse  // One-cycle pulse on the selected edge.
);

	logic s1_ff, s2_ff, s3_ff, lvl_ff, pulse_ff;

	// Three-stage synchroniser; only s2 reads s1.
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else begin
			s1_ff <= pin;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// A change counts only once stages two and three agree, filtering runts.
	always_ff @(posedge clk) begin
		if (rst) begin
			lvl_ff   <= 1'b0;
			pulse_ff <= 1'b0;
		end else begin
			pulse_ff <= 1'b0;
			if (s2_ff == s3_ff && s3_ff != lvl_ff) begin
				lvl_ff   <= s3_ff;
				pulse_ff <= (s3_ff != fall_sel);
			end
		end
	end

	assign level      = lvl_ff;
	assign edge_pulse = pulse_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_EDGE_DIR: assert property (edge_pulse |-> level == !$past(fall_sel) && $past(level) != level)
		else $error("mark pulse on wrong edge");

endmodule // mdl_mark_sync

`default_nettype wire

// file: verilog/mdl_store_mem.sv
`timescale 1ns/100ps
`default_nettype none

module mdl_store_mem (
	input  wire logic clk,  // System clock.
	mdl_store_if.mem  port  // Capture write and bus read port.
);

	// ****************************************************************
	// Storage area of 16-bit words.
	// ****************************************************************
	logic [15:0] mem_q [0:32767];

	// Captures write one word per cycle.
	always_ff @(posedge clk) begin
		if (port.wr_en) begin
			mem_q[port.wr_addr] <= port.wr_data;
		end
	end

	// Asynchronous read keeps the bus answer at one wait cycle.
	assign port.rd_data = mem_q[port.rd_addr];

endmodule // mdl_store_mem

`default_nettype wire

// file: tb/mdl_mark_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Mark sensor model: one high pulse on the pin per request.
// ****************************************************************
module mdl_mark_model #(
	parameter int HOLD = 8  // Cycles the pin stays high per pulse.
) (
	input  wire logic clk,  // System clock.
	input  wire logic rst,  // Synchronous reset, active high.
	input  wire logic go,   // One-cycle request for one pulse.
	output logic      mark  // Mark sensor pin.
);
	logic [7:0] left_ff;

	// Both pin edges stay HOLD cycles apart, more than the sequencer needs.
	always_ff @(posedge clk) begin
		if (rst) begin
			left_ff <= 8'h00;
		end else if (go && left_ff == 8'h00) begin
			left_ff <= HOLD[7:0];
		end else if (left_ff != 8'h00) begin
			left_ff <= left_ff - 8'h01;
		end
	end

	// The pin idles low, as a released sensor output does.
	assign mark = (left_ff != 8'h00);
endmodule // mdl_mark_model

`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "mdl_defines.svh"

module testbench;
	logic        clk_sys = 1'b0;
	logic        rst     = 1'b1;
	logic        go      = 1'b0;
	logic        mark;
	logic [63:0] data_in = 64'h0;
	logic [15:0] addr    = 16'h0000;
	logic        rd_en   = 1'b0;
	logic        wr_en   = 1'b0;
	logic [31:0] wdata   = 32'h0;
	logic [31:0] rdata;
	logic        waitreq;
	integer      seed    = 32'h114d;
	int          fail_count = 0;
	int          checks     = 0;

	// 50 MHz system clock.
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end

	mdl_mark_model #(.HOLD(8)) mdl_mark_model_inst (
		.clk  (clk_sys),
		.rst  (rst),
		.go   (go),
		.mark (mark)
	);

	mdl_top mdl_top_inst (
		.CLK_SYS         (clk_sys),
		.RST             (rst),
		.MARK_IN         (mark),
		.DATA_IN         (data_in),
		.AVS_ADDRESS     (addr),
		.AVS_READ        (rd_en),
		.AVS_WRITE       (wr_en),
		.AVS_WRITEDATA   (wdata),
		.AVS_BYTEENABLE  (4'hf),
		.AVS_READDATA    (rdata),
		.AVS_WAITREQUEST (waitreq)
	);

	// ****************************************************************
	// Shared tasks.
	// ****************************************************************
	task automatic complete_run();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// The request holds until waitrequest is sampled low; read data is taken there.
	task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk_sys);
		addr  <= a;
		wdata <= wd;
		wr_en <= wr;
		rd_en <= !wr;
		do begin
			@(posedge clk_sys);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		rd    = rdata;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		if (n >= 50) begin
			fail_count++;
			complete_run();
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] wd);
		logic [31:0] dummy;
		bus(1'b1, a, wd, dummy);
	endtask

	task automatic rd_chk(input string name, input logic [15:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(name, r, exp);
	endtask

	// One pin pulse; the source value changes to b when the pin falls.
	task automatic pulse(input logic [63:0] a, input logic [63:0] b);
		@(posedge clk_sys);
		data_in <= a;
		go      <= 1'b1;
		@(posedge clk_sys);
		go      <= 1'b0;
		repeat (8) @(posedge clk_sys);
		data_in <= b;
		repeat (16) @(posedge clk_sys);
	endtask

	// Control word: enable, mode, falling select, range enable, type.
	function automatic logic [31:0] ctrl(input logic [1:0] m, input logic f,
		input logic g, input logic [1:0] t);
		return {25'h0, t, g, f, m, 1'b1};
	endfunction

	function automatic logic [63:0] rnd();
		return {$random(seed), $random(seed)};
	endfunction

	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial begin
		logic [63:0] d [0:3];
		logic [31:0] v;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		rd_chk("ctrl", `MDL_REG_CTRL, 32'h0);
		rd_chk("num_det", `MDL_REG_NUM_DET, 32'h1);
		rd_chk("counter", `MDL_REG_COUNTER, 32'h0);
		rd_chk("unmapped", 16'h0100, 32'h0);
		// Every mode code; the unused code leaves the field alone.
		for (int m = 0; m < 4; m++) begin
			if (m < 3) v = ctrl(m[1:0], 1'b0, 1'b0, 2'h0);
			wr(`MDL_REG_CTRL, ctrl(m[1:0], 1'b0, 1'b0, 2'h0));
			rd_chk("mode", `MDL_REG_CTRL, v);
		end
		for (int k = 0; k < 4; k++) d[k] = rnd();
		// Continuous mode overwrites slot 0 and counts every store.
		wr(`MDL_REG_CTRL, ctrl(2'h0, 1'b0, 1'b0, 2'h0));
		pulse(d[0], d[0]);
		pulse(d[1], d[1]);
		rd_chk("cont_word", 16'h8000, {16'h0, d[1][15:0]});
		rd_chk("cont_cnt", `MDL_REG_COUNTER, 32'h2);
		// Falling edge select latches the value seen when the pin falls.
		wr(`MDL_REG_COUNTER, 32'h0);
		wr(`MDL_REG_CTRL, ctrl(2'h0, 1'b1, 1'b0, 2'h0));
		pulse(d[2], d[3]);
		rd_chk("fall_word", 16'h8000, {16'h0, d[3][15:0]});
		rd_chk("fall_cnt", `MDL_REG_COUNTER, 32'h1);
		// Range filter drops an outside value without counting it.
		wr(`MDL_REG_LOWER_LO, 32'h100);
		wr(`MDL_REG_UPPER_LO, 32'h200);
		wr(`MDL_REG_CTRL, ctrl(2'h0, 1'b0, 1'b1, 2'h0));
		pulse(64'h300, 64'h300);
		pulse(64'h150, 64'h150);
		rd_chk("rng_word", 16'h8000, 32'h150);
		rd_chk("rng_cnt", `MDL_REG_COUNTER, 32'h2);
		// Signed 16-bit bounds: minus 8 lies inside, the most negative value below.
		wr(`MDL_REG_LOWER_LO, 32'hfff0);
		pulse(64'hfff8, 64'hfff8);
		pulse(64'h8000, 64'h8000);
		rd_chk("rng_neg", 16'h8000, 32'hfff8);
		rd_chk("rng_cnt2", `MDL_REG_COUNTER, 32'h3);
		// Fixed count of two with 32-bit data: the third edge is ignored.
		for (int k = 0; k < 4; k++) d[k] = rnd();
		wr(`MDL_REG_NUM_DET, 32'h2);
		wr(`MDL_REG_COUNTER, 32'h0);
		wr(`MDL_REG_CTRL, ctrl(2'h1, 1'b0, 1'b0, 2'h1));
		for (int k = 0; k < 3; k++) pulse(d[k], d[k]);
		rd_chk("fix_cnt", `MDL_REG_COUNTER, 32'h2);
		rd_chk("fix_last", `MDL_REG_LAST_LO, d[1][31:0]);
		rd_chk("fix_full", `MDL_REG_STATUS, 32'h4);
		wr(`MDL_REG_COUNTER, 32'h0);
		pulse(d[3], d[3]);
		rd_chk("fix_cnt2", `MDL_REG_COUNTER, 32'h1);
		rd_chk("fix_w0", 16'h8000, {16'h0, d[3][15:0]});
		rd_chk("fix_w2", 16'h8002, {16'h0, d[1][15:0]});
		rd_chk("fix_w3", 16'h8003, {16'h0, d[1][31:16]});
		// Ring of three with 64-bit data: the fourth store wraps to slot 0.
		for (int k = 0; k < 4; k++) d[k] = rnd();
		wr(`MDL_REG_NUM_DET, 32'h3);
		wr(`MDL_REG_COUNTER, 32'h0);
		wr(`MDL_REG_CTRL, ctrl(2'h2, 1'b0, 1'b0, 2'h2));
		for (int k = 0; k < 4; k++) pulse(d[k], d[k]);
		rd_chk("ring_cnt", `MDL_REG_COUNTER, 32'h4);
		for (int j = 0; j < 4; j++) begin
			rd_chk("ring_wrap", 16'h8000 + j[15:0], {16'h0, d[3][16*j+:16]});
		end
		rd_chk("ring_s1", 16'h8004, {16'h0, d[1][15:0]});
		rd_chk("ring_s2", 16'h8008, {16'h0, d[2][15:0]});
		// Detection count limits: out-of-range writes are dropped whole.
		wr(`MDL_REG_NUM_DET, 32'h0);
		rd_chk("num_lo", `MDL_REG_NUM_DET, 32'h3);
		wr(`MDL_REG_NUM_DET, 32'h2001);
		rd_chk("num_hi", `MDL_REG_NUM_DET, 32'h3);
		wr(`MDL_REG_NUM_DET, 32'h2000);
		rd_chk("num_max", `MDL_REG_NUM_DET, 32'h2000);
		complete_run();
	end
endmodule // testbench

`default_nettype wire
